//--- pkg/scp_pkg.sv
// package for the sar conversion and power control block
package scp_pkg;
	// register byte offsets
	localparam logic [11:0] SCP_CTRL_OFS   = 12'h000;
	localparam logic [11:0] SCP_STATUS_OFS = 12'h004;
	localparam logic [11:0] SCP_COUNT_OFS  = 12'h008;
	localparam logic [11:0] SCP_RESULT_OFS = 12'h00C;
	// control field positions
	localparam int CTRL_START_BIT  = 0;
	localparam int CTRL_PD_BIT     = 1;
	localparam int CTRL_REF_POWERDOWN_PIN_BIT  = 2;
	localparam int CTRL_REFBUF_POWERDOWN_PIN_BIT  = 3;
	localparam int CTRL_RESET_BIT  = 4;
	localparam int CTRL_CS_BIT     = 5;
	localparam int CTRL_RD_BIT     = 6;
	localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0060;
	// status field positions
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_INIT_BIT  = 1;
	localparam int ST_PD_BIT    = 2;
	localparam int ST_BUSOE_BIT = 3;
	localparam int ST_REF_LO    = 4;
	localparam int ST_VALID_BIT = 6;
	// reference source codes
	localparam logic [1:0] REF_INTERNAL = 2'h0;
	localparam logic [1:0] REF_EXT_1V2  = 2'h1;
	localparam logic [1:0] REF_EXT_2V5  = 2'h2;
	localparam logic [1:0] REF_INVALID  = 2'h3;
	// timing
	localparam int CLK_MHZ        = 50;
	localparam int CONV_TIME_NS   = 400;
	localparam int CONV_CYCLES    = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int INIT_CONV_NUM  = 128;
	localparam int RST_INIT_NS    = 200;
	localparam int RST_INIT_CYC   = (RST_INIT_NS * CLK_MHZ + 999) / 1000;
	localparam int RESULT_W       = 16;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage

//--- design/scp_result_mem.sv
// result store: one word with registered read data
`timescale 1ns/100ps
module scp_result_mem
	import scp_pkg::*;
#(
	parameter int W = RESULT_W
) (
	input  wire logic         pclk,     // clock
	input  wire logic         presetn,  // async reset low
	input  wire logic         clr,      // clear stored word
	input  wire logic         wr,       // write strobe
	input  wire logic [W-1:0] wdata,    // word in
	output logic      [W-1:0] rdata     // registered word out
);
	initial begin
		if (W < 1 || W > 32) $error("bad width");
	end

	// store with clear priority
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= '0;
		end else if (clr) begin
			rdata <= '0;
		end else if (wr) begin
			rdata <= wdata;
		end
	end
endmodule

//--- design/scp_ctrl.sv
// conversion start, initialization and reference power control over apb
//
// Function
// - falling start edge launches a conversion
// - running conversion ignores start and power-down
// - start independent of select and read
// - initialization at power-up and power-down exit; here only on pin power-down exit, not when the software bit clears
// - power-down keeps supplies, reset stays low
// - interface logic active in acquisition too
// - ref pins disable bandgap and buffer
// - both low selects internal 2.048 V
// - ref high buffer low: external 1.2 V
// - both high: external 2.5 V direct
// - reset rise aborts, tristates; fall clears, inits
// - busy pulses during reset initialization
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module scp_ctrl
	import scp_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYCLES,
	parameter int INIT_NUM = INIT_CONV_NUM,
	parameter int RINIT_CYC = RST_INIT_CYC
) (
	input  wire logic        pclk,                 // apb clock
	input  wire logic        presetn,              // async reset low
	input  wire logic        psel,                 // apb select
	input  wire logic        penable,              // apb enable
	input  wire logic        pwrite,               // apb direction
	input  wire logic [11:0] paddr,                // apb address
	input  wire logic [31:0] pwdata,               // apb write data
	output logic      [31:0] prdata,               // apb read data
	output logic             pready,               // apb ready
	output logic             pslverr,              // apb error
	input  wire logic        conversion_start_n,   // start pin, low active
	input  wire logic        power_down_pin,       // power-down pin
	input  wire logic        reset_pin,            // reset pin
	input  wire logic [15:0] sar_result,           // sar core result
	output logic             busy,                 // busy output
	output logic             conv_active,          // sar core run
	output logic             ref_powerdown_pin,    // bandgap off
	output logic             refbuf_powerdown_pin, // buffer off
	output logic             data_bus_oe,          // data bus drive enable
	output logic             init_active           // initialization running
);
	initial begin
		if (CONV_CYC < 2 || CONV_CYC > 65535) $error("bad conv cycles");
		if (INIT_NUM < 1 || INIT_NUM > 255) $error("bad init count");
		if (RINIT_CYC < 1 || RINIT_CYC > 65535) $error("bad reset init");
	end

	typedef enum logic [1:0] {S_IDLE, S_CONV, S_RINIT} scp_state_t;

	// writable control bits; upper bits read back as zero
	localparam logic [31:0] CTRL_WR_MASK = 32'h0000_007F;

	// sequencer overview
	// idle: waits for a start edge from the pin or the software bit
	// conv: counts down the conversion time, deaf to start and power-down
	// rinit: short busy pulse after the reset pin is released
	// a rising reset edge leaves any state for idle at once
	// a falling reset edge always enters rinit, even from conv
	//
	// initialization bookkeeping
	// init_left_q counts conversions the host still has to throw away
	// loaded at power-up and on every exit from pin power-down; clearing the software power-down bit does not reload it
	// each completed conversion takes one off while above zero
	// a completed reset initialization clears it in one step
	// init_active follows the next value, so it drops with the last result
	//
	// pin handling
	// start, power-down and reset come from outside this clock domain
	// each passes a three-stage shift chain before it is used
	// a level only counts once stages two and three agree
	// while they differ the previously accepted level is kept
	// edges compare the accepted level with its copy one cycle on
	// so a one-cycle glitch never reaches the sequencer
	// start reaches the sequencer three to four cycles after the pin
	//
	// register bus
	// every transfer gets pready one cycle into its access phase
	// writes land on the edge that sees pready high, not before
	// read data is fetched one cycle early and shown only with pready
	// unmapped offsets answer with pslverr and read as zero
	// the bus answers in every state: acquisition, conversion and init
	//
	// reference pins
	// the two power-down outputs are plain control bits, no sequencing
	// status reports which reference source that pairing selects
	// buffer off with bandgap on is no supported pairing: code invalid

	// accepted pin level: new only when stages two and three agree
	function automatic logic pin_level(input logic [1:0] stages, input logic last);
		pin_level = (stages[0] == stages[1]) ? stages[1] : last;
	endfunction

	// counter step shared by conversion and reset initialization
	function automatic logic [15:0] dec16(input logic [15:0] v);
		dec16 = v - 16'h0001;
	endfunction

	// reference source from {buffer off, bandgap off}
	function automatic logic [1:0] ref_decode(input logic [1:0] sel);
		case (sel)
			2'h0:    ref_decode = REF_INTERNAL;
			2'h1:    ref_decode = REF_EXT_1V2;
			2'h3:    ref_decode = REF_EXT_2V5;
			default: ref_decode = REF_INVALID;
		endcase
	endfunction

	scp_state_t  state_q, state_d;
	logic [31:0] ctrl_q;
	logic [15:0] cnt_q, cnt_d;
	logic [7:0]  init_left_q, init_left_d;
	logic [2:0]  cs_sync_q, pd_sync_q, rs_sync_q;
	logic        cs_last_q, pd_last_q, rs_last_q;
	logic        busy_q, oe_q, conv_q, initf_q;
	logic [31:0] prdata_q;
	logic        pready_q, pslverr_q;
	logic [15:0] mem_rdata;

	// pin filters: change counts when stages two and three agree
	wire cs_lvl    = pin_level(cs_sync_q[2:1], cs_last_q);
	wire pd_lvl    = pin_level(pd_sync_q[2:1], pd_last_q);
	wire rs_lvl    = pin_level(rs_sync_q[2:1], rs_last_q);

	// effective control: pin or software bit
	wire pd_eff    = pd_lvl | ctrl_q[CTRL_PD_BIT];
	wire rs_eff    = rs_lvl | ctrl_q[CTRL_RESET_BIT];
	wire start_fall = cs_last_q & ~cs_lvl;
	wire sw_start   = ctrl_q[CTRL_START_BIT];
	wire pd_exit    = pd_last_q & ~pd_lvl;
	wire rs_rise    = ~rs_last_q & rs_lvl;
	wire rs_fall    = rs_last_q & ~rs_lvl;
	wire conv_done  = (state_q == S_CONV) && (cnt_q == 16'h0001);

	// apb decode
	wire        apb_acc  = psel & penable;
	wire        apb_wr   = apb_acc & pready_q & pwrite;  // lands on the pready edge
	wire        hit_ctrl = paddr == SCP_CTRL_OFS;
	wire        hit_st   = paddr == SCP_STATUS_OFS;
	wire        hit_cnt  = paddr == SCP_COUNT_OFS;
	wire        hit_res  = paddr == SCP_RESULT_OFS;
	wire        hit_any  = hit_ctrl | hit_st | hit_cnt | hit_res;
	wire [1:0]  ref_sel  = {ctrl_q[CTRL_REFBUF_POWERDOWN_PIN_BIT], ctrl_q[CTRL_REF_POWERDOWN_PIN_BIT]};
	wire [1:0]  ref_code = ref_decode(ref_sel);
	wire [31:0] status_w = {25'h0, (init_left_q == 8'h00), ref_code, oe_q, pd_eff,
			initf_q, busy_q};
	wire [31:0] rd_mux   = hit_ctrl ? ctrl_q :
			hit_st  ? status_w :
			hit_cnt ? {24'h0, init_left_q} :
			hit_res ? {16'h0, mem_rdata} : RDATA_ZERO;

	// next-state logic for conversion and initialization
	always_comb begin
		state_d     = state_q;
		cnt_d       = cnt_q;
		init_left_d = init_left_q;
		case (state_q)
			S_IDLE: begin
				if ((start_fall || sw_start) && !rs_eff && !pd_eff) begin
					state_d = S_CONV;
					cnt_d   = 16'(CONV_CYC);
				end
			end
			S_CONV: begin
				// start and power-down ignored until done
				cnt_d = dec16(cnt_q);
				if (conv_done) begin
					state_d = S_IDLE;
					if (init_left_q != 8'h00) init_left_d = init_left_q - 8'h01;
				end
			end
			S_RINIT: begin
				cnt_d = dec16(cnt_q);
				if (cnt_q == 16'h0001) begin
					state_d     = S_IDLE;
					init_left_d = 8'h00;
				end
			end
			default: state_d = S_IDLE;
		endcase
		if (pd_exit) init_left_d = 8'(INIT_NUM);
		if (rs_rise) begin
			state_d = S_IDLE;
		end else if (rs_fall) begin
			state_d = S_RINIT;
			cnt_d   = 16'(RINIT_CYC);
		end
	end

	// start pin chain, idle high so no false edge after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_sync_q <= 3'h7;
			cs_last_q <= 1'b1;
		end else begin
			cs_sync_q <= {cs_sync_q[1:0], conversion_start_n};
			cs_last_q <= cs_lvl;
		end
	end

	// power-down pin chain and accepted level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_sync_q <= 3'h0;
			pd_last_q <= 1'b0;
		end else begin
			pd_sync_q <= {pd_sync_q[1:0], power_down_pin};
			pd_last_q <= pd_lvl;
		end
	end

	// reset pin chain and accepted level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rs_sync_q <= 3'h0;
			rs_last_q <= 1'b0;
		end else begin
			rs_sync_q <= {rs_sync_q[1:0], reset_pin};
			rs_last_q <= rs_lvl;
		end
	end

	// sequencer state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= S_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// conversion and reset-init down counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// discard counter; reset starts with initialization pending
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_left_q <= 8'(INIT_NUM);
		end else begin
			init_left_q <= init_left_d;
		end
	end

	// busy through conversion and reset initialization
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= (state_d == S_CONV) || (state_d == S_RINIT);
		end
	end

	// core run strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_q <= 1'b0;
		end else begin
			conv_q <= state_d == S_CONV;
		end
	end

	// bus drives only when selected, read and out of reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_q <= 1'b0;
		end else begin
			oe_q <= ~rs_eff & ~ctrl_q[CTRL_CS_BIT] & ~ctrl_q[CTRL_RD_BIT];
		end
	end

	// initialization flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			initf_q <= 1'b1;
		end else begin
			initf_q <= (init_left_d != 8'h00) || (state_d == S_RINIT);
		end
	end

	// control register; start bit self-clears, power-down holds supplies
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= CTRL_RESET_VAL;
		end else if (apb_wr && hit_ctrl) begin
			ctrl_q <= pwdata & CTRL_WR_MASK;
		end else begin
			ctrl_q[CTRL_START_BIT] <= 1'b0;
		end
	end

	// apb answer one cycle after access start; bus stays live always
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= apb_acc & ~pready_q;
		end
	end

	// error flag for unmapped offsets, alongside pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= apb_acc & ~pready_q & ~hit_any;
		end
	end

	// read data shown only in the pready cycle of a read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= RDATA_ZERO;
		end else begin
			prdata_q <= (apb_acc & ~pready_q & ~pwrite) ? rd_mux : RDATA_ZERO;
		end
	end

	// result word, cleared at reset falling edge
	scp_result_mem #(.W(RESULT_W)) u_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (rs_fall),
		.wr      (conv_done),
		.wdata   (sar_result),
		.rdata   (mem_rdata)
	);

	assign prdata               = prdata_q;
	assign pready               = pready_q;
	assign pslverr              = pslverr_q;
	assign busy                 = busy_q;
	assign conv_active          = conv_q;
	assign ref_powerdown_pin    = ctrl_q[CTRL_REF_POWERDOWN_PIN_BIT];
	assign refbuf_powerdown_pin = ctrl_q[CTRL_REFBUF_POWERDOWN_PIN_BIT];
	assign data_bus_oe          = oe_q;
	assign init_active          = initf_q;
endmodule

//--- tb/scp_ctrl_chk.sv
// assertion checker for the conversion and power control block
`timescale 1ns/100ps
module scp_ctrl_chk
	import scp_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYCLES
) (
	input wire logic pclk,               // clock
	input wire logic presetn,            // reset low
	input wire logic psel,               // select
	input wire logic penable,            // enable
	input wire logic pready,             // ready
	input wire logic conversion_start_n, // start pin
	input wire logic power_down_pin,     // pd pin
	input wire logic reset_pin,          // reset pin
	input wire logic busy,               // busy
	input wire logic conv_active,        // converting
	input wire logic data_bus_oe,        // bus drive
	input wire logic init_active         // init running
);
	logic [15:0] cnt_q; // cycles spent in this conversion
	// count cycles while converting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= conv_active ? cnt_q + 16'h0001 : 16'h0000;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_busy_conv; conv_active |-> busy; endproperty
	a_busy_conv: assert property (p_busy_conv) else $error("busy low");
	property p_start;
		$fell(conversion_start_n) && !busy && !power_down_pin && !reset_pin |-> ##[1:8] conv_active;
	endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_len; $fell(conv_active) && !reset_pin |-> cnt_q == CONV_CYC; endproperty
	a_len: assert property (p_len) else $error("bad length");
	property p_no_abort; conv_active && !reset_pin |=> conv_active || cnt_q == CONV_CYC; endproperty
	a_no_abort: assert property (p_no_abort) else $error("cut short");
	property p_rst_abort;
		$rose(reset_pin) ##1 reset_pin [*6] |-> !conv_active && !busy && !data_bus_oe;
	endproperty
	a_rst_abort: assert property (p_rst_abort) else $error("no abort");
	property p_rst_init; $fell(reset_pin) |-> ##[1:8] (busy && init_active && !conv_active); endproperty
	a_rst_init: assert property (p_rst_init) else $error("no init pulse");
	property p_pd_init; $fell(power_down_pin) |-> ##[1:8] init_active; endproperty
	a_pd_init: assert property (p_pd_init) else $error("no init");
	property p_apb_live; psel && penable && !pready |=> pready; endproperty
	a_apb_live: assert property (p_apb_live) else $error("no answer");
endmodule
bind scp_ctrl scp_ctrl_chk #(.CONV_CYC(CONV_CYC)) i_scp_ctrl_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.conversion_start_n(conversion_start_n), .power_down_pin(power_down_pin),
	.reset_pin(reset_pin), .busy(busy), .conv_active(conv_active),
	.data_bus_oe(data_bus_oe), .init_active(init_active));

//--- tb/scp_host_model.sv
// host model driving the start, power-down and reset pins
`timescale 1ns/100ps
module scp_host_model (
	input  wire logic pclk,               // clock
	output logic      conversion_start_n, // start pin
	output logic      power_down_pin,     // pd pin
	output logic      reset_pin           // reset pin
);
	// idle pins: powered, out of reset
	initial begin
		conversion_start_n = 1'b1;
		power_down_pin = 1'b0;
		reset_pin = 1'b0;
	end
	// short low pulse, released well inside the low-time limit
	task automatic start();
		@(posedge pclk);
		conversion_start_n <= 1'b0;
		repeat (2) @(posedge pclk);
		conversion_start_n <= 1'b1;
	endtask
	// power-down and reset levels; a reset pulse gives fast init
	task automatic pins(input logic pd, input logic rst);
		@(posedge pclk);
		power_down_pin <= pd;
		reset_pin <= rst;
	endtask
endmodule

//--- tb/scp_ctrl_tb_top.sv
// testbench for the conversion and power control block
`timescale 1ns/100ps
module scp_ctrl_tb_top;
	import scp_pkg::*;
	localparam int IN = 2;
	localparam logic [1:0] RC [4] = '{REF_INTERNAL, REF_EXT_1V2, REF_INVALID, REF_EXT_2V5};
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] res = 16'h0;
	logic        pready, pslverr, err, busy, conv_active, ref_pd, buf_pd, oe, init_act;
	logic        start_n, pd, rst;
	int          n_mismatch = 0, cmp_count = 0;
	always #10 pclk = ~pclk;
	scp_ctrl #(.CONV_CYC(8), .INIT_NUM(IN), .RINIT_CYC(2)) i_scp_ctrl (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.conversion_start_n(start_n), .power_down_pin(pd), .reset_pin(rst), .sar_result(res),
		.busy(busy), .conv_active(conv_active), .ref_powerdown_pin(ref_pd),
		.refbuf_powerdown_pin(buf_pd), .data_bus_oe(oe), .init_active(init_act));
	scp_host_model i_scp_host_model (.pclk(pclk), .conversion_start_n(start_n),
		.power_down_pin(pd), .reset_pin(rst));
	// compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge pclk);
		end
		if (n >= 50) n_mismatch++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask
	// bounded wait for a busy level
	task automatic wait_busy(input logic v);
		int n;
		n = 0;
		while (busy !== v && n < 100) begin
			n++;
			@(posedge pclk);
		end
		chk({31'h0, busy}, {31'h0, v});
	endtask
	task automatic report_and_stop();
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#40000;
		n_mismatch++;
		report_and_stop();
	end
	// main sequence
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(SCP_CTRL_OFS, 32'hFFFF_FFFF, CTRL_RESET_VAL);
		rdc(SCP_COUNT_OFS, 32'hFFFF_FFFF, IN);
		chk({31'h0, init_act}, 32'h1);
		apb(1'b0, 12'h010, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, SCP_CTRL_OFS, 32'h60 | 32'(i << 2));
			chk({30'h0, buf_pd, ref_pd}, 32'(i));
			rdc(SCP_STATUS_OFS, 32'h30, {26'h0, RC[i], 4'h0});
		end
		apb(1'b1, SCP_CTRL_OFS, 32'h0);
		res <= 16'hA5C3;
		i_scp_host_model.start();
		wait_busy(1'b1);
		chk({30'h0, conv_active, oe}, 32'h3);
		wait_busy(1'b0);
		rdc(SCP_RESULT_OFS, 32'hFFFF, 32'hA5C3);
		rdc(SCP_COUNT_OFS, 32'hFFFF_FFFF, IN - 1);
		apb(1'b1, SCP_CTRL_OFS, CTRL_RESET_VAL);
		res <= 16'h1234;
		i_scp_host_model.start();
		wait_busy(1'b1);
		i_scp_host_model.start();
		wait_busy(1'b0);
		repeat (10) @(posedge pclk);
		chk({31'h0, busy}, 32'h0);
		rdc(SCP_STATUS_OFS, 32'h43, 32'h40);
		res <= 16'h5A0F;
		i_scp_host_model.start();
		wait_busy(1'b1);
		i_scp_host_model.pins(1'b1, 1'b0);
		wait_busy(1'b0);
		rdc(SCP_RESULT_OFS, 32'hFFFF, 32'h5A0F);
		i_scp_host_model.pins(1'b0, 1'b0);
		repeat (8) @(posedge pclk);
		rdc(SCP_COUNT_OFS, 32'hFFFF_FFFF, IN);
		apb(1'b1, SCP_CTRL_OFS, 32'h0);
		i_scp_host_model.start();
		wait_busy(1'b1);
		i_scp_host_model.pins(1'b0, 1'b1);
		repeat (6) @(posedge pclk);
		chk({30'h0, busy, oe}, 32'h0);
		i_scp_host_model.pins(1'b0, 1'b0);
		wait_busy(1'b1);
		wait_busy(1'b0);
		rdc(SCP_RESULT_OFS, 32'hFFFF, 32'h0);
		rdc(SCP_STATUS_OFS, 32'h03, 32'h0);
		res <= 16'h0F0F;
		apb(1'b1, SCP_CTRL_OFS, 32'h1);
		wait_busy(1'b1);
		wait_busy(1'b0);
		rdc(SCP_RESULT_OFS, 32'hFFFF, 32'h0F0F);
		report_and_stop();
	end
endmodule
